// *** src/trace_pkg.sv ***
// Constants shared by the bank multiplexer trace core
package trace_pkg;
    localparam int MIN_PINS = 4;
    localparam int MAX_PINS = 128;
    localparam int MAX_BANKS = 32;
    localparam int MAX_SIGNALS_PER_PIN = 64;
    localparam int TDM_FACTOR = 2;
    localparam int SEL_W = 5;
    localparam logic [SEL_W-1:0] SEL_RESET = 5'h00;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SAMPLE_CYCLES = 2;

    typedef enum logic {
        VARIANT_TIMING,
        VARIANT_STATE
    } variant_type;
endpackage

// *** src/bank_select_ctrl.sv ***
// Test-clock control flops and handshake crossing of the bank select
module bank_select_ctrl (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    input wire logic i_tck,
    input wire logic i_sel_wr,
    input wire logic [trace_pkg::SEL_W-1:0] i_sel_data,
    output logic [trace_pkg::SEL_W-1:0] o_sel_tck,
    output logic o_sel_busy,
    output logic [trace_pkg::SEL_W-1:0] o_sel_clk
);
    import trace_pkg::*;

    logic [SEL_W-1:0] sel_q;
    logic req_q;
    logic ack_meta_q;
    logic ack_sync_q;
    logic req_meta_q;
    logic req_sync_q;
    logic ack_q;
    logic [SEL_W-1:0] sel_clk_q;

    // Select flop written on the test clock, refused while a transfer is open
    always_ff @(posedge i_tck or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sel_q <= SEL_RESET;
            req_q <= 1'b0;
        end else if (i_sel_wr && !o_sel_busy) begin
            sel_q <= i_sel_data;
            req_q <= ~req_q;
        end
    end

    // Acknowledge returned to the test clock
    always_ff @(posedge i_tck or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ack_meta_q <= 1'b0;
            ack_sync_q <= 1'b0;
        end else begin
            ack_meta_q <= ack_q;
            ack_sync_q <= ack_meta_q;
        end
    end

    // Request toggle into the design clock
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            req_meta_q <= 1'b0;
            req_sync_q <= 1'b0;
        end else if (i_ce) begin
            req_meta_q <= req_q;
            req_sync_q <= req_meta_q;
        end
    end

    // Select copy taken while the test side holds it stable
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sel_clk_q <= SEL_RESET;
            ack_q <= 1'b0;
        end else if (i_ce && (req_sync_q != ack_q)) begin
            sel_clk_q <= sel_q;
            ack_q <= req_sync_q;
        end
    end

    assign o_sel_tck = sel_q;
    assign o_sel_busy = req_q ^ ack_sync_q;
    assign o_sel_clk = sel_clk_q;
endmodule

// *** src/bank_mux_trace_core.sv ***
// Bank multiplexer trace core driving debug pins for a logic analyzer
module bank_mux_trace_core #(
    parameter int PINS = 8,
    parameter int BANKS = 4,
    parameter bit STATE_CORE = 1'b1,
    parameter bit TDM2X = 1'b0,
    parameter int LANES = PINS * ((STATE_CORE && TDM2X) ? trace_pkg::TDM_FACTOR : 1)
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    input wire logic i_tck,
    input wire logic i_sel_wr,
    input wire logic [trace_pkg::SEL_W-1:0] i_sel_data,
    input wire logic [BANKS*LANES-1:0] i_probe,
    output logic [PINS-1:0] o_pins,
    output logic o_trace_clk,
    output logic [trace_pkg::SEL_W-1:0] o_sel_rd,
    output logic o_sel_busy,
    output logic o_status_state,
    output logic o_status_tdm
);
    import trace_pkg::*;

    // Pin and bank counts checked against the supported build range, a miss only clears the state status
    localparam bit PINS_OK = (PINS >= MIN_PINS) && (PINS <= MAX_PINS);
    localparam bit BANKS_OK = (BANKS == 1) || (BANKS == 2) || (BANKS == 4) || (BANKS == 8)
        || (BANKS == 16) || (BANKS == MAX_BANKS);
    // Signals per pin checked against the documented maximum, an excess only clears the state status
    localparam bit REACH_OK = (BANKS * LANES / PINS) <= MAX_SIGNALS_PER_PIN;
    // Double multiplexing only on the state variant
    localparam bit TDM_ON = STATE_CORE && TDM2X;
    localparam variant_type VARIANT = STATE_CORE ? VARIANT_STATE : VARIANT_TIMING;

    logic [SEL_W-1:0] sel_tck;
    logic [SEL_W-1:0] sel_clk;
    logic status_state_q;
    logic status_tdm_q;

    // Pick one bank worth of lanes; out of range selects read zero
    function automatic logic [LANES-1:0] pick_bank(input logic [BANKS*LANES-1:0] v,
                                                   input logic [SEL_W-1:0] s);
        logic [LANES-1:0] r;
        r = '0;
        for (int b = 0; b < BANKS; b++) begin
            if (s == SEL_W'(b)) begin
                r = v[b*LANES +: LANES];
            end
        end
        return r;
    endfunction

    bank_select_ctrl u_ctrl (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_ce(i_ce),
        .i_tck(i_tck),
        .i_sel_wr(i_sel_wr),
        .i_sel_data(i_sel_data),
        .o_sel_tck(sel_tck),
        .o_sel_busy(o_sel_busy),
        .o_sel_clk(sel_clk)
    );

    // Variant status flops on the test clock, loaded after reset release
    always_ff @(posedge i_tck or negedge i_arst_n) begin
        if (!i_arst_n) begin
            status_state_q <= 1'b0;
            status_tdm_q <= 1'b0;
        end else begin
            status_state_q <= (VARIANT == VARIANT_STATE) && PINS_OK && BANKS_OK
                && REACH_OK;
            status_tdm_q <= TDM_ON;
        end
    end

    assign o_sel_rd = sel_tck;
    assign o_status_state = status_state_q;
    assign o_status_tdm = status_tdm_q;

    generate
        if (STATE_CORE) begin : g_state
            logic [BANKS*LANES-1:0] cap_q;
            logic [LANES-1:0] word_q;
            logic [PINS-1:0] pins_q;
            logic [LANES-1:0] pick_d;
            logic phase_q;
            logic trace_clk_q;

            // Selected bank of the captured probes
            assign pick_d = pick_bank(cap_q, sel_clk);

            // Every probe captured on the design clock before the mux
            always_ff @(posedge i_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    cap_q <= '0;
                end else if (i_ce) begin
                    cap_q <= i_probe;
                end
            end

            // Two-cycle sampling period phase
            always_ff @(posedge i_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    phase_q <= 1'b0;
                end else if (i_ce) begin
                    phase_q <= ~phase_q;
                end
            end

            // Bank word latched once per sampling period
            always_ff @(posedge i_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    word_q <= '0;
                end else if (i_ce && !phase_q) begin
                    word_q <= pick_d;
                end
            end

            // Pins: low half in first slot, high half in second when doubled
            always_ff @(posedge i_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    pins_q <= '0;
                end else if (i_ce) begin
                    if (!phase_q) begin
                        pins_q <= pick_d[PINS-1:0];
                    end else if (TDM_ON) begin
                        pins_q <= word_q[LANES-1 -: PINS];
                    end
                end
            end

            // Forwarded sampling clock, rising mid-period
            always_ff @(posedge i_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    trace_clk_q <= 1'b0;
                end else if (i_ce) begin
                    trace_clk_q <= phase_q;
                end
            end

            assign o_pins = pins_q;
            assign o_trace_clk = trace_clk_q;
        end else begin : g_timing
            logic [LANES-1:0] pick_c;

            // Pure combinational path from probes to pads
            assign pick_c = pick_bank(i_probe, sel_tck);
            assign o_pins = pick_c[PINS-1:0];
            assign o_trace_clk = 1'b0;
        end
    endgenerate
endmodule

// *** dv/trace_chk.sv ***
// Port-level checks for the trace core
module trace_chk #(
    parameter int PINS = 8,
    parameter int BANKS = 4,
    parameter bit STATE_CORE = 1'b1,
    parameter bit TDM2X = 1'b0,
    parameter int LANES = 8
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    input wire logic i_tck,
    input wire logic i_sel_wr,
    input wire logic [trace_pkg::SEL_W-1:0] i_sel_data,
    input wire logic [BANKS*LANES-1:0] i_probe,
    input wire logic [PINS-1:0] o_pins,
    input wire logic o_trace_clk,
    input wire logic [trace_pkg::SEL_W-1:0] o_sel_rd,
    input wire logic o_sel_busy,
    input wire logic o_status_state,
    input wire logic o_status_tdm
);
    // Accepted select write and a running design clock
    sequence s_take;
        i_sel_wr && !o_sel_busy;
    endsequence
    sequence s_run;
        STATE_CORE && i_ce ##1 i_ce ##1 i_ce;
    endsequence
    a_sel_take: assert property (@(posedge i_tck) disable iff (!i_arst_n)
        s_take |=> o_sel_busy && o_sel_rd == $past(i_sel_data)) else $error("select lost");
    a_busy_refuse: assert property (@(posedge i_tck) disable iff (!i_arst_n)
        i_sel_wr && o_sel_busy |=> $stable(o_sel_rd)) else $error("busy write taken");
    a_idle_hold: assert property (@(posedge i_tck) disable iff (!i_arst_n)
        !i_sel_wr |=> $stable(o_sel_rd)) else $error("select moved");
    a_busy_bound: assert property (@(posedge i_tck) disable iff (!i_arst_n)
        $rose(o_sel_busy) |-> ##[1:8] !o_sel_busy) else $error("busy stuck");
    a_status_kind: assert property (@(posedge i_tck) disable iff (!i_arst_n)
        1'b1 ##1 1'b1 |-> o_status_state == STATE_CORE) else $error("bad variant");
    a_status_tdm: assert property (@(posedge i_tck) disable iff (!i_arst_n)
        1'b1 ##1 1'b1 |-> o_status_tdm == (STATE_CORE && TDM2X)) else $error("bad tdm");
    a_clk_toggle: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        s_run |-> o_trace_clk != $past(o_trace_clk)) else $error("trace clock stuck");
    a_ce_freeze: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        STATE_CORE && !i_ce |=> $stable(o_pins) && $stable(o_trace_clk))
        else $error("moved while frozen");
endmodule
bind bank_mux_trace_core trace_chk #(.PINS(PINS), .BANKS(BANKS), .STATE_CORE(STATE_CORE),
    .TDM2X(TDM2X), .LANES(LANES)) u_chk (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_ce(i_ce),
    .i_tck(i_tck),
    .i_sel_wr(i_sel_wr),
    .i_sel_data(i_sel_data),
    .i_probe(i_probe),
    .o_pins(o_pins),
    .o_trace_clk(o_trace_clk),
    .o_sel_rd(o_sel_rd),
    .o_sel_busy(o_sel_busy),
    .o_status_state(o_status_state),
    .o_status_tdm(o_status_tdm)
);

// *** dv/analyzer_model.sv ***
// Logic analyzer capturing both slots from the forwarded clock
module analyzer_model #(
    parameter int PINS = 8
) (
    input wire logic i_trace_clk,
    input wire logic [PINS-1:0] i_pins,
    output logic [PINS-1:0] o_lo,
    output logic [PINS-1:0] o_hi
);
    timeunit 1ns;
    timeprecision 100ps;
    // Sample each slot shortly after its forwarded clock edge
    always @(negedge i_trace_clk) #2 o_lo = i_pins;
    always @(posedge i_trace_clk) #2 o_hi = i_pins;
endmodule

// *** dv/testbench.sv ***
// Self-checking bench for the trace core
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
    $display("mismatch t=%0t got %h exp %h", $time, (a), (e)); end end
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clk = 0, i_tck = 0, i_arst_n = 0, i_ce = 1, i_sel_wr = 0;
    logic [4:0] i_sel_data = 5'h00, o_sel_rd, sel;
    logic [63:0] i_probe = 64'h0;
    logic [7:0] o_pins, lo, hi, held, t_pins;
    logic o_trace_clk, o_sel_busy, o_status_state, o_status_tdm, t_state, t_tdm;
    int mismatches = 0, n_checks = 0;
    // Clocks, test clock offset in phase
    always #5 i_clk = ~i_clk;
    initial begin
        #3.3;
        forever #15 i_tck = ~i_tck;
    end
    bank_mux_trace_core #(.PINS(8), .BANKS(4), .STATE_CORE(1'b1), .TDM2X(1'b1)) u_dut (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_ce(i_ce),
        .i_tck(i_tck),
        .i_sel_wr(i_sel_wr),
        .i_sel_data(i_sel_data),
        .i_probe(i_probe),
        .o_pins(o_pins),
        .o_trace_clk(o_trace_clk),
        .o_sel_rd(o_sel_rd),
        .o_sel_busy(o_sel_busy),
        .o_status_state(o_status_state),
        .o_status_tdm(o_status_tdm)
    );
    // Timing variant asking for doubling, which it must refuse
    bank_mux_trace_core #(.PINS(8), .BANKS(4), .STATE_CORE(1'b0), .TDM2X(1'b1)) u_dut_timing (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_ce(i_ce),
        .i_tck(i_tck),
        .i_sel_wr(i_sel_wr),
        .i_sel_data(i_sel_data),
        .i_probe(i_probe[31:0]),
        .o_pins(t_pins),
        .o_trace_clk(),
        .o_sel_rd(),
        .o_sel_busy(),
        .o_status_state(t_state),
        .o_status_tdm(t_tdm)
    );
    analyzer_model #(.PINS(8)) u_la (.i_trace_clk(o_trace_clk), .i_pins(o_pins), .o_lo(lo),
        .o_hi(hi));
    // Expected slot of a bank w lanes wide, zero for an absent bank
    function automatic logic [7:0] exp_pins(input logic [63:0] p, input logic [4:0] b,
                                            input int h, input int w);
        return (b < 5'h04) ? p[b*w+h*8+:8] : 8'h00;
    endfunction
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Write a, then b while busy, then wait for the crossing
    task automatic write_sel(input logic [4:0] a, input logic [4:0] b);
        int n;
        @(posedge i_tck);
        #1 i_sel_wr = 1'b1;
        i_sel_data = a;
        @(posedge i_tck);
        #1 i_sel_data = b;
        @(posedge i_tck);
        #1 i_sel_wr = 1'b0;
        for (n = 0; n < 40 && o_sel_busy !== 1'b0; n++) @(posedge i_tck);
        if (n == 40) begin
            mismatches++;
            report_and_stop();
        end
    endtask
    initial begin
        void'($urandom(78));
        repeat (20) @(posedge i_clk);
        #1 i_arst_n = 1'b1;
        repeat (3) @(posedge i_tck);
        `CHK(o_status_state, 1'b1)
        `CHK(o_status_tdm, 1'b1)
        `CHK(t_state, 1'b0)
        `CHK(t_tdm, 1'b0)
        for (int i = 0; i < 12; i++) begin
            sel = (i < 5) ? 5'(i) : (i == 5) ? 5'h1f : 5'($urandom);
            write_sel(sel, ~sel);
            `CHK(o_sel_rd, sel)
            @(posedge i_clk);
            #1 i_probe = {$urandom, $urandom};
            repeat (12) @(posedge i_clk);
            `CHK(lo, exp_pins(i_probe, sel, 0, 16))
            `CHK(hi, exp_pins(i_probe, sel, 1, 16))
            `CHK(t_pins, exp_pins({32'h0, i_probe[31:0]}, sel, 0, 8))
            $display("test %0d bank %0d done", i, sel);
        end
        @(posedge i_clk);
        #1 i_ce = 1'b0;
        held = o_pins;
        i_probe = ~i_probe;
        #1;
        `CHK(t_pins, exp_pins({32'h0, i_probe[31:0]}, sel, 0, 8))
        repeat (4) @(posedge i_clk);
        `CHK(o_pins, held)
        $display("test clock enable done");
        report_and_stop();
    end
endmodule
